// ==== design/plcc_port.sv ====
// Purpose: One switch port's link capability and control register pair
// Assumes: Writes are single-cycle with full word data
// Notes: Upstream selects hardwired bits; training status is set by a retrain request and cleared by train_done from the core
`timescale 1ns/100ps
`default_nettype none
module plcc_port #(
    parameter logic [7:0] PORT_IDX = 8'h00,
    parameter bit UPSTREAM = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register writes
    input wire logic wr_cap,
    input wire logic wr_ctl,
    input wire logic [31:0] wdata,
    // Side channel override load
    input wire logic ovr_load,
    input wire logic [31:0] ovr_data,
    // Link core status
    input wire logic train_done,
    // Register views and controls
    output logic [31:0] cap_word,
    output logic [15:0] ctl_word,
    output logic link_disable,
    output logic retrain_pulse,
    output logic training,
    output logic [1:0] aspm_en,
    output logic l0s_rx_allowed,
    output logic [12:0] fts_count,
    output logic [12:0] ts1_count
);
    logic [1:0] aspm_sup_r;
    logic [2:0] l0s_lat_r;
    logic [2:0] l1_lat_r;
    logic cpm_r;
    logic [7:0] port_num_r;
    logic [1:0] aspm_r;
    logic dis_r;
    logic ccc_r;
    logic esyn_r;
    logic hawd_r;
    logic bwmi_r;
    logic abwi_r;
    logic retr_r;
    logic train_r;
    logic retr_req;

    // Override-capable capability fields; only side channel reaches them
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aspm_sup_r <= plcc_pkg::ASPM_SUP_RST;
            l0s_lat_r <= plcc_pkg::L0S_LAT_RST;
            l1_lat_r <= plcc_pkg::L1_LAT_RST;
            cpm_r <= UPSTREAM;
            port_num_r <= PORT_IDX;
        end else if (ovr_load) begin
            aspm_sup_r <= ovr_data[plcc_pkg::OVR_ASPM_LSB +: 2];
            l0s_lat_r <= ovr_data[plcc_pkg::OVR_L0S_LSB +: 3];
            l1_lat_r <= ovr_data[plcc_pkg::OVR_L1_LSB +: 3];
            cpm_r <= ovr_data[plcc_pkg::OVR_CPM_BIT];
            port_num_r <= ovr_data[plcc_pkg::OVR_PORT_LSB +: 8];
        end
    end

    // Capability word; config writes are ignored since every field is read-only
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[plcc_pkg::CAP_SPD_LSB +: 4] = plcc_pkg::SPD_RST;
        cap_word[plcc_pkg::CAP_WID_LSB +: 6] = plcc_pkg::WID_RST;
        cap_word[plcc_pkg::CAP_ASPM_LSB +: 2] = aspm_sup_r;
        cap_word[plcc_pkg::CAP_L0S_LSB +: 3] = l0s_lat_r;
        cap_word[plcc_pkg::CAP_L1_LSB +: 3] = l1_lat_r;
        cap_word[plcc_pkg::CAP_CPM_BIT] = cpm_r;
        cap_word[plcc_pkg::CAP_SD_BIT] = !UPSTREAM;
        cap_word[plcc_pkg::CAP_DLA_BIT] = 1'b0;
        cap_word[plcc_pkg::CAP_BWN_BIT] = !UPSTREAM;
        cap_word[plcc_pkg::CAP_PORT_LSB +: 8] = port_num_r;
    end

    // Writable control bits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aspm_r <= plcc_pkg::ASPM_CTL_RST;
            dis_r <= 1'b0;
            ccc_r <= 1'b0;
            esyn_r <= 1'b0;
            hawd_r <= 1'b0;
            bwmi_r <= 1'b0;
            abwi_r <= 1'b0;
        end else if (wr_ctl) begin
            aspm_r <= wdata[plcc_pkg::CTL_ASPM_LSB +: 2];
            dis_r <= wdata[plcc_pkg::CTL_DIS_BIT] & !UPSTREAM;
            ccc_r <= wdata[plcc_pkg::CTL_CCC_BIT];
            esyn_r <= wdata[plcc_pkg::CTL_ESYN_BIT];
            hawd_r <= wdata[plcc_pkg::CTL_HAWD_BIT];
            bwmi_r <= wdata[plcc_pkg::CTL_BWMI_BIT] & !UPSTREAM;
            abwi_r <= wdata[plcc_pkg::CTL_ABWI_BIT] & !UPSTREAM;
        end
    end

    // Retrain is a write-one pulse, never stored for readback
    assign retr_req = wr_ctl && wdata[plcc_pkg::CTL_RETR_BIT] && !UPSTREAM;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            retr_r <= 1'b0;
        end else begin
            retr_r <= retr_req;
        end
    end

    // Training flag: a new request wins over a completion in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            train_r <= 1'b0;
        end else if (retr_req) begin
            train_r <= 1'b1;
        end else if (train_done) begin
            train_r <= 1'b0;
        end
    end

    // Control word view; RCB, retrain and reserved read zero
    always_comb begin
        ctl_word = 16'h0000;
        ctl_word[plcc_pkg::CTL_ASPM_LSB +: 2] = aspm_r;
        ctl_word[plcc_pkg::CTL_RCB_BIT] = 1'b0;
        ctl_word[plcc_pkg::CTL_DIS_BIT] = dis_r;
        ctl_word[plcc_pkg::CTL_RETR_BIT] = 1'b0;
        ctl_word[plcc_pkg::CTL_CCC_BIT] = ccc_r;
        ctl_word[plcc_pkg::CTL_ESYN_BIT] = esyn_r;
        ctl_word[plcc_pkg::CTL_HAWD_BIT] = hawd_r;
        ctl_word[plcc_pkg::CTL_BWMI_BIT] = bwmi_r;
        ctl_word[plcc_pkg::CTL_ABWI_BIT] = abwi_r;
    end

    // Controls toward the link layer
    assign link_disable = dis_r;
    assign retrain_pulse = retr_r;
    assign training = train_r;
    assign aspm_en = aspm_r;
    assign l0s_rx_allowed = 1'b1;
    assign fts_count = esyn_r ? plcc_pkg::FTS_EXT : 13'h0000;
    assign ts1_count = esyn_r ? plcc_pkg::TS1_EXT : 13'h0000;

    // Capability write strobe is deliberately unused: the word is read-only
    logic unused_cap;
    assign unused_cap = wr_cap;
endmodule : plcc_port
`default_nettype wire

// ==== design/plcc_pkg.sv ====
// Purpose: Shared constants for the per-port link capability and control registers
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Port 0 is the upstream port, ports 1..3 are downstream
package plcc_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] LCAP_OFF = 8'hCC;
    localparam logic [7:0] LCTL_OFF = 8'hD0;
    localparam logic [7:0] OVR_OFF = 8'hE0;
    localparam logic [7:0] STAT_OFF = 8'hE4;
    // Capability field positions
    localparam int CAP_SPD_LSB = 0;
    localparam int CAP_WID_LSB = 4;
    localparam int CAP_ASPM_LSB = 10;
    localparam int CAP_L0S_LSB = 12;
    localparam int CAP_L1_LSB = 15;
    localparam int CAP_CPM_BIT = 18;
    localparam int CAP_SD_BIT = 19;
    localparam int CAP_DLA_BIT = 20;
    localparam int CAP_BWN_BIT = 21;
    localparam int CAP_PORT_LSB = 24;
    // Capability reset values
    localparam logic [3:0] SPD_RST = 4'h2;
    localparam logic [5:0] WID_RST = 6'h01;
    localparam logic [1:0] ASPM_SUP_RST = 2'h3;
    localparam logic [2:0] L0S_LAT_RST = 3'h3;
    localparam logic [2:0] L1_LAT_RST = 3'h0;
    // Control field positions
    localparam int CTL_ASPM_LSB = 0;
    localparam int CTL_RCB_BIT = 3;
    localparam int CTL_DIS_BIT = 4;
    localparam int CTL_RETR_BIT = 5;
    localparam int CTL_CCC_BIT = 6;
    localparam int CTL_ESYN_BIT = 7;
    localparam int CTL_HAWD_BIT = 9;
    localparam int CTL_BWMI_BIT = 10;
    localparam int CTL_ABWI_BIT = 11;
    localparam logic [1:0] ASPM_CTL_RST = 2'h0;
    // Override port bit layout (side channel load)
    localparam int OVR_ASPM_LSB = 0;
    localparam int OVR_L0S_LSB = 2;
    localparam int OVR_L1_LSB = 5;
    localparam int OVR_CPM_BIT = 8;
    localparam int OVR_PORT_LSB = 16;
    // Ordered set counts for extended synch
    localparam logic [12:0] FTS_EXT = 13'h1000;
    localparam logic [12:0] TS1_EXT = 13'h0400;
    localparam int NPORT = 4;
endpackage : plcc_pkg

// ==== design/plcc_regs.sv ====
// Purpose: Four-port link capability and control register bank
// Assumes: Port 0 upstream, ports 1..3 downstream; synchronous active-low reset
// Notes: Port select is a separate input; zero-count outputs mean normal synch length
`timescale 1ns/100ps
`default_nettype none
module plcc_regs (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [1:0] PORT_SEL,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Link core status per port
    input wire logic [3:0] TRAIN_DONE,
    // Per-port link controls
    output logic [3:0] LINK_DISABLE,
    output logic [3:0] RETRAIN,
    output logic [7:0] ASPM_EN,
    output logic [3:0] L0S_RX_ALLOWED,
    output logic [51:0] FTS_COUNT,
    output logic [51:0] TS1_COUNT
);
    logic [31:0] cap_words [plcc_pkg::NPORT];
    logic [15:0] ctl_words [plcc_pkg::NPORT];
    logic [3:0] training;
    logic [3:0] wr_cap;
    logic [3:0] wr_ctl;
    logic [3:0] ovr_load;
    logic [31:0] rd_nxt;
    logic [31:0] rdata_r;

    // Decode one-hot write strobes per port
    always_comb begin
        wr_cap = 4'h0;
        wr_ctl = 4'h0;
        ovr_load = 4'h0;
        if (WR && ADDR == plcc_pkg::LCAP_OFF) begin
            wr_cap[PORT_SEL] = 1'b1;
        end else if (WR && ADDR == plcc_pkg::LCTL_OFF) begin
            wr_ctl[PORT_SEL] = 1'b1;
        end else if (WR && ADDR == plcc_pkg::OVR_OFF) begin
            ovr_load[PORT_SEL] = 1'b1;
        end
    end

    // One register pair per port; port 0 is the upstream port
    genvar g;
    generate
        for (g = 0; g < plcc_pkg::NPORT; g++) begin : g_port
            plcc_port #(
                .PORT_IDX(8'(g)),
                .UPSTREAM(g == 0)
            ) u_port (
                .clk(CLK),
                .reset_n(RESET_N),
                .wr_cap(wr_cap[g]),
                .wr_ctl(wr_ctl[g]),
                .wdata(WDATA),
                .ovr_load(ovr_load[g]),
                .ovr_data(WDATA),
                .train_done(TRAIN_DONE[g]),
                .cap_word(cap_words[g]),
                .ctl_word(ctl_words[g]),
                .link_disable(LINK_DISABLE[g]),
                .retrain_pulse(RETRAIN[g]),
                .training(training[g]),
                .aspm_en(ASPM_EN[2*g +: 2]),
                .l0s_rx_allowed(L0S_RX_ALLOWED[g]),
                .fts_count(FTS_COUNT[13*g +: 13]),
                .ts1_count(TS1_COUNT[13*g +: 13])
            );
        end
    endgenerate

    // Read mux; unmapped addresses return zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (ADDR == plcc_pkg::LCAP_OFF) begin
            rd_nxt = cap_words[PORT_SEL];
        end else if (ADDR == plcc_pkg::LCTL_OFF) begin
            rd_nxt = {16'h0000, ctl_words[PORT_SEL]};
        end else if (ADDR == plcc_pkg::STAT_OFF) begin
            rd_nxt = {28'h0000000, training};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_r <= 32'h0000_0000;
        end else if (RD) begin
            rdata_r <= rd_nxt;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end
    assign RDATA = rdata_r;
endmodule : plcc_regs
`default_nettype wire

// ==== dv/plcc_regs_sva.sv ====
// Purpose: Port-level checks of the link register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Synch counts are checked on port 1 only, to keep the file short
`timescale 1ns/100ps
`default_nettype none
module plcc_regs_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [1:0] PORT_SEL,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Link controls
    input wire logic [3:0] LINK_DISABLE,
    input wire logic [3:0] RETRAIN,
    input wire logic [7:0] ASPM_EN,
    input wire logic [3:0] L0S_RX_ALLOWED,
    input wire logic [51:0] FTS_COUNT,
    input wire logic [51:0] TS1_COUNT
);
    // All checks share the core clock and its reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_rx_l0s_kept: assert property (L0S_RX_ALLOWED == 4'hF)
        else $error("l0s receive blocked");
    a_up_never_acts: assert property (!LINK_DISABLE[0] && !RETRAIN[0])
        else $error("upstream control active");
    a_retrain_fires: assert property (WR && ADDR == plcc_pkg::LCTL_OFF && WDATA[5] &&
        PORT_SEL != 2'h0 |=> RETRAIN == 4'h1 << $past(PORT_SEL)) else $error("no retrain pulse");
    a_retrain_cause: assert property (RETRAIN != 4'h0 |->
        $past(WR && ADDR == plcc_pkg::LCTL_OFF && WDATA[5])) else $error("stray retrain pulse");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("rdata not idle");
    a_cap_fixed: assert property ($past(RD && ADDR == plcc_pkg::LCAP_OFF) |->
        RDATA[9:0] == 10'h012 && RDATA[23:22] == 2'h0 && !RDATA[20]) else $error("cap bits");
    a_ctl_zero: assert property ($past(RD && ADDR == plcc_pkg::LCTL_OFF) |->
        RDATA[31:12] == 20'h0 && !RDATA[8] && !RDATA[5] && RDATA[3:2] == 2'h0)
        else $error("ctl zero bits");
    a_up_ctl_ro: assert property ($past(RD && ADDR == plcc_pkg::LCTL_OFF && PORT_SEL == 2'h0)
        |-> RDATA[11:10] == 2'h0 && !RDATA[4]) else $error("upstream ctl bits");
    a_ctl_hold: assert property (!$past(WR && ADDR == plcc_pkg::LCTL_OFF) |->
        $stable(LINK_DISABLE) && $stable(ASPM_EN)) else $error("control changed");
    a_synch_pair: assert property (FTS_COUNT[25:13] == TS1_COUNT[25:13] << 2 &&
        TS1_COUNT[25:13] inside {13'h0000, 13'h0400}) else $error("synch counts");
endmodule : plcc_regs_sva
bind plcc_regs plcc_regs_sva i_sva (.CLK(CLK), .RESET_N(RESET_N), .PORT_SEL(PORT_SEL),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_DISABLE(LINK_DISABLE),
    .RETRAIN(RETRAIN), .ASPM_EN(ASPM_EN), .L0S_RX_ALLOWED(L0S_RX_ALLOWED),
    .FTS_COUNT(FTS_COUNT), .TS1_COUNT(TS1_COUNT));
`default_nettype wire

// ==== dv/plcc_regs_tb_top.sv ====
// Purpose: Self-checking bench for the link register bank
// Assumes: Port 0 upstream; override load at 0xE0, training status at 0xE4
// Notes: The model keeps control, capability and training bits per port
`timescale 1ns/100ps
`default_nettype none
module plcc_regs_tb_top;
    logic CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [1:0] PORT_SEL = 2'h0;
    logic [7:0] ADDR = 8'h00, ASPM_EN;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0] TRAIN_DONE = 4'h0, LINK_DISABLE, RETRAIN, L0S_RX_ALLOWED, trn_m;
    logic [51:0] FTS_COUNT, TS1_COUNT;
    logic [15:0] ctl_m [4];
    logic [31:0] cap_m [4];
    int fails = 0, check_count = 0, cyc = 0;
    // 250 MHz core clock
    always #2 CLK = ~CLK;
    plcc_regs i_dut (.CLK(CLK), .RESET_N(RESET_N), .PORT_SEL(PORT_SEL), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TRAIN_DONE(TRAIN_DONE),
        .LINK_DISABLE(LINK_DISABLE), .RETRAIN(RETRAIN), .ASPM_EN(ASPM_EN),
        .L0S_RX_ALLOWED(L0S_RX_ALLOWED), .FTS_COUNT(FTS_COUNT), .TS1_COUNT(TS1_COUNT));
    // Case equality so an unknown never matches
    task automatic cmp(input string nm, input logic [51:0] e, input logic [51:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // Strobes change just after an edge; a gap cycle follows each access
    task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PORT_SEL <= 2'(p);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input int p, input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        PORT_SEL <= 2'(p);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        cmp("rdata", {20'h0, e}, {20'h0, RDATA});
    endtask : rd
    // Reset image: upstream has clock PM, downstream surprise-down and bw notify
    task automatic mdl_reset;
        for (int p = 0; p < 4; p++) begin
            ctl_m[p] = 16'h0000;
            cap_m[p] = 32'h00003C12 | (p == 0 ? 32'h00040000 : 32'h00280000) | (p << 24);
        end
        trn_m = 4'h0;
    endtask : mdl_reset
    task automatic chk_all;
        logic [51:0] f, t;
        logic [7:0] a;
        logic [3:0] l;
        for (int p = 0; p < 4; p++) begin
            rd(p, plcc_pkg::LCAP_OFF, cap_m[p]);
            rd(p, plcc_pkg::LCTL_OFF, {16'h0, ctl_m[p]});
            l[p] = ctl_m[p][4];
            a[2*p+:2] = ctl_m[p][1:0];
            f[13*p+:13] = ctl_m[p][7] ? 13'h1000 : 13'h0000;
            t[13*p+:13] = ctl_m[p][7] ? 13'h0400 : 13'h0000;
        end
        rd(0, plcc_pkg::STAT_OFF, {28'h0, trn_m});
        rd(1, 8'h40, 32'h0);
        cmp("disable", {48'h0, l}, {48'h0, LINK_DISABLE});
        cmp("aspm", {44'h0, a}, {44'h0, ASPM_EN});
        cmp("fts", f, FTS_COUNT);
        cmp("ts1", t, TS1_COUNT);
        cmp("l0s_rx", 52'hF, {48'h0, L0S_RX_ALLOWED});
    endtask : chk_all
    // Main sequence: reset image, random control writes, training, override, reset again
    initial begin
        int p;
        logic [31:0] d;
        void'($urandom(32'h9274610E));
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        mdl_reset();
        chk_all();
        for (int i = 0; i < 16; i++) begin
            p = $urandom % 4;
            d = $urandom;
            wr(p, plcc_pkg::LCTL_OFF, d);
            cmp("retrain", (p != 0 && d[5]) ? 52'h1 << p : 52'h0, {48'h0, RETRAIN});
            ctl_m[p] = d[15:0] & (p == 0 ? 16'h02C3 : 16'h0ED3);
            trn_m[p] = trn_m[p] | (p != 0 && d[5]);
            wr(p, plcc_pkg::LCAP_OFF, ~d);
            chk_all();
        end
        @(posedge CLK);
        TRAIN_DONE <= 4'hF;
        @(posedge CLK);
        TRAIN_DONE <= 4'h0;
        trn_m = 4'h0;
        chk_all();
        d = $urandom & 32'h00FF01FF;
        wr(2, plcc_pkg::OVR_OFF, d);
        cap_m[2] = {d[23:16], cap_m[2][23:19], d[8], d[7:5], d[4:2], d[1:0], cap_m[2][9:0]};
        chk_all();
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        mdl_reset();
        chk_all();
        wrap_up();
    end
    // Hang guard, far above the roughly 500 cycles the run needs
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 8000) begin
            fails++;
            wrap_up();
        end
    end
endmodule : plcc_regs_tb_top
`default_nettype wire
